// *** hdl/cdr_loop_control.sv ***
// retiming fifo and digital loop control of the clock and data recovery
`timescale 1ns/1ns
// What this block does
// - at most one front-end path is selected, none for an undefined code
// - signal loss only on limiting amp, capped
// - slice from trim, user or auto
// - manual boost unless adapting, adaptation above 5.5G
// - downsample samples before one phase detector
// - phase shifter and oscillator loops track jitter
// - clock late: oscillator up, delay down
// - loop filter is pure integrator
// - third loop sets oscillator and decimation
// - oscillator word saturates at tuning extremes
// - wrapping shifter, fifo absorbs 32 UI
// - acquire to 250 ppm, then enable loop
// - reference mode uses written division ratio
// - low-frequency jitter keeps shifter near center
// - over 1000 ppm: flag, restart from lowest
// - double N or step up, shrink steps
module retime_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clock_in,
	input  wire logic             arst_n_in,
	// filling side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// draining side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             do_wr;
	logic             do_rd;

	// extra pointer bit tells full from empty
	assign in_ready_out  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
	assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
	assign out_data_out  = mem[rd_ptr_reg[AW-1:0]];
	assign do_wr = in_valid_in && in_ready_out;
	assign do_rd = out_valid_out && out_ready_in;

	// storage is written only, no reset needed
	always_ff @(posedge clock_in) begin
		if (do_wr) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
		end
	end

	// pointers
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule

module cdr_loop_control (
	// clock and reset
	input  wire logic                      clock_in,
	input  wire logic                      arst_n_in,
	// front end and slicer controls
	input  wire logic [1:0]                input_sel_in,
	input  wire logic [7:0]                los_thresh_in,
	input  wire logic [7:0]                signal_level_in,
	input  wire logic [1:0]                slice_src_in,
	input  wire logic [6:0]                slice_user_in,
	input  wire logic [6:0]                slice_trim_in,
	input  wire logic                      eq_adapt_en_in,
	input  wire logic [3:0]                eq_boost_in,
	input  wire logic                      eq_more_boost_in,
	// sampler pins
	input  wire logic                      data_samp_in,
	input  wire logic                      edge_samp_in,
	// frequency comparator and reference mode
	input  wire cdr_pkg::freq_cmp_t        freq_cmp_in,
	input  wire logic                      ref_mode_in,
	input  wire logic [cdr_pkg::DIV_W-1:0] ref_div_in,
	// retimed data
	input  wire logic                      rd_ready_in,
	output logic                           rd_valid_out,
	output logic [cdr_pkg::PACK_W-1:0]     rd_data_out,
	// front end and slicer status
	output logic [2:0]                     path_sel_out,
	output logic                           signal_loss_detect_out,
	output logic [6:0]                     slice_out,
	output logic [3:0]                     eq_boost_out,
	// loop state
	output logic [cdr_pkg::DIV_W-1:0]      div_exp_out,
	output logic [cdr_pkg::OSC_W-1:0]      digital_osc_out,
	output logic [cdr_pkg::PH_W-1:0]       phase_shifter_out,
	output logic                           osc_sat_out,
	output logic                           lock_loss_flag_out,
	output logic                           pll_en_out,
	output logic                           overflow_out
);
	import cdr_pkg::*;

	// decimation count for a ratio of 2**exp
	function automatic logic [15:0] ratio_top(input logic [DIV_W-1:0] e);
		ratio_top = 16'((17'h1 << e) - 17'h1);
	endfunction

	logic [1:0] data_sync_reg;
	logic [1:0] edge_sync_reg;
	logic [15:0] dec_cnt_reg;
	logic        dec_en;
	logic        d_prev_reg;
	logic        late;
	logic        early;
	logic signed [INT_W-1:0] int_reg;
	logic [PH_W-1:0] ph_reg;
	logic        wrap_up;
	logic        wrap_dn;
	logic [7:0]  tick_reg;
	logic        tick;
	acq_state_t  acq_reg;
	logic [OSC_W-1:0] base_reg;
	logic [OSC_W-1:0] step_reg;
	logic [OSC_W-1:0] step_next;
	logic        stepped_reg;
	logic [DIV_W-1:0] div_reg;
	logic signed [OSC_W+1:0] osc_sum;
	logic [OSC_W-1:0] osc_next;
	logic        sat_next;
	logic [7:0]  los_thr;
	logic signed [7:0] bal_reg;
	logic [6:0]  auto_slice_reg;
	logic        eq_allowed;
	logic [PACK_W-1:0] pack_reg;
	logic [1:0]  pack_cnt_reg;
	logic        dup_reg;
	logic        wr_valid_reg;
	logic        wr_ready;
	logic        shift_ok;
	logic        shift_bit;
	logic        shift_val;
	logic        fifo_valid;
	logic [PACK_W-1:0] fifo_data;
	logic        fifo_take;

	// sampler bits come from the fast clock, resynchronise them
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			data_sync_reg <= 2'h0;
			edge_sync_reg <= 2'h0;
		end else begin
			data_sync_reg <= {data_sync_reg[0], data_samp_in};
			edge_sync_reg <= {edge_sync_reg[0], edge_samp_in};
		end
	end

	// downsampler keeps one sample in 2**div_reg
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dec_cnt_reg <= 16'h0000;
		end else if (dec_en) begin
			dec_cnt_reg <= 16'h0000;
		end else begin
			dec_cnt_reg <= dec_cnt_reg + 16'h0001;
		end
	end
	assign dec_en = dec_cnt_reg >= ratio_top(div_reg);

	// binary phase detector: edge sample equal to new bit means late
	assign late  = dec_en && (data_sync_reg[1] != d_prev_reg)
		&& (edge_sync_reg[1] == data_sync_reg[1]);
	assign early = dec_en && (data_sync_reg[1] != d_prev_reg)
		&& (edge_sync_reg[1] == d_prev_reg);
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			d_prev_reg <= 1'b0;
		end else if (dec_en) begin
			d_prev_reg <= data_sync_reg[1];
		end
	end

	// slow tick for centring and adaptation steps
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tick_reg <= 8'h00;
		end else begin
			tick_reg <= tick ? 8'h00 : tick_reg + 8'h01;
		end
	end
	assign tick = tick_reg == TICK_TOP;

	// integrator only: a steady phase error keeps ramping the word
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			int_reg <= '0;
		end else if (!pll_en_out) begin
			int_reg <= '0;
		end else if (late && !(osc_sat_out && osc_sum > 0)) begin
			int_reg <= int_reg + INT_W'(1);
		end else if (early && !(osc_sat_out && osc_sum < 0)) begin
			int_reg <= int_reg - INT_W'(1);
		end
	end

	// oscillator word = acquired base plus integrator, clamped
	always_comb begin
		osc_sum = $signed({2'b00, base_reg})
			+ (OSC_W+2)'(int_reg >>> INT_SHIFT);
		osc_next = osc_sum[OSC_W-1:0];
		sat_next = 1'b0;
		if (osc_sum < 0) begin
			osc_next = OSC_MIN;
			sat_next = 1'b1;
		end else if (osc_sum > $signed({2'b00, OSC_MAX})) begin
			osc_next = OSC_MAX;
			sat_next = 1'b1;
		end
	end
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			digital_osc_out <= OSC_MIN;
			osc_sat_out     <= 1'b0;
		end else begin
			digital_osc_out <= osc_next;
			osc_sat_out     <= sat_next;
		end
	end

	// phase shifter accumulator wraps freely across unit intervals
	assign wrap_dn = late && (ph_reg == '0);
	assign wrap_up = early && (ph_reg == PH_TOP);
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ph_reg <= PH_CENTER;
		end else if (late) begin
			ph_reg <= ph_reg - 1'b1;
		end else if (early) begin
			ph_reg <= ph_reg + 1'b1;
		end else if (tick && pll_en_out && !osc_sat_out) begin
			// slow bleed back; the oscillator loop absorbs it
			if (ph_reg > PH_CENTER) begin
				ph_reg <= ph_reg - 1'b1;
			end else if (ph_reg < PH_CENTER) begin
				ph_reg <= ph_reg + 1'b1;
			end
		end
	end
	assign phase_shifter_out = ph_reg;

	// step shrinks on each overshoot, never to zero
	assign step_next = (step_reg > STEP_MIN) ? step_reg >> 1 : STEP_MIN;

	// frequency acquisition state machine
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acq_reg     <= ACQ_RESET;
			base_reg    <= OSC_MIN;
			step_reg    <= STEP_INIT;
			stepped_reg <= 1'b0;
			div_reg     <= '0;
		end else begin
			case (acq_reg)
			ACQ_RESET: begin
				base_reg    <= OSC_MIN;
				step_reg    <= STEP_INIT;
				stepped_reg <= 1'b0;
				div_reg     <= ref_mode_in ? ref_div_in : '0;
				acq_reg     <= ACQ_MEASURE;
			end
			ACQ_MEASURE: begin
				if (freq_cmp_in.valid) begin
					if (freq_cmp_in.diff_ppm <= LOCK_PPM) begin
						acq_reg <= ACQ_LOCKED;
					end else if (freq_cmp_in.samp_fast) begin
						if (!stepped_reg && !ref_mode_in
							&& div_reg < DIV_MAX) begin
							div_reg <= div_reg + 1'b1;
						end else begin
							step_reg <= step_next;
							base_reg <= (base_reg > step_next)
								? base_reg - step_next : OSC_MIN;
						end
					end else begin
						stepped_reg <= 1'b1;
						base_reg <= (OSC_MAX - base_reg > step_reg)
							? base_reg + step_reg : OSC_MAX;
					end
				end
			end
			ACQ_LOCKED: begin
				if (freq_cmp_in.valid
					&& freq_cmp_in.diff_ppm > LOSS_PPM) begin
					acq_reg <= ACQ_RESET;
				end
			end
			default: begin
				acq_reg <= ACQ_RESET;
			end
			endcase
		end
	end

	// lock flags follow the state one cycle later
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lock_loss_flag_out <= 1'b1;
			pll_en_out         <= 1'b0;
			div_exp_out        <= '0;
		end else begin
			lock_loss_flag_out <= acq_reg != ACQ_LOCKED;
			pll_en_out         <= acq_reg == ACQ_LOCKED;
			div_exp_out        <= div_reg;
		end
	end

	// front-end path: undefined code selects no path
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			path_sel_out <= PATH_LIMAMP;
		end else begin
			case (input_sel_in)
			SEL_LIMAMP: path_sel_out <= PATH_LIMAMP;
			SEL_EQ:     path_sel_out <= PATH_EQ;
			SEL_UNITY:  path_sel_out <= PATH_UNITY;
			default:    path_sel_out <= PATH_NONE;
			endcase
		end
	end

	// zero threshold means default; programmed value is capped
	assign los_thr = (los_thresh_in == 8'h00) ? LOS_DEF_MV
		: (los_thresh_in > LOS_MAX_MV) ? LOS_MAX_MV : los_thresh_in;

	// hysteresis stops the alarm from chattering near threshold
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			signal_loss_detect_out <= 1'b0;
		end else if (input_sel_in != SEL_LIMAMP) begin
			signal_loss_detect_out <= 1'b0;
		end else if (signal_level_in < los_thr) begin
			signal_loss_detect_out <= 1'b1;
		end else if (signal_level_in >= los_thr + LOS_HYST_MV) begin
			signal_loss_detect_out <= 1'b0;
		end
	end

	// auto slice: balance ones and zeros for the widest eye
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bal_reg        <= 8'sh00;
			auto_slice_reg <= SLICE_MID;
		end else if (bal_reg >= BAL_LIM) begin
			bal_reg <= 8'sh00;
			if (auto_slice_reg < SLICE_MAX) begin
				auto_slice_reg <= auto_slice_reg + 1'b1;
			end
		end else if (bal_reg <= -BAL_LIM) begin
			bal_reg <= 8'sh00;
			if (auto_slice_reg > SLICE_MIN) begin
				auto_slice_reg <= auto_slice_reg - 1'b1;
			end
		end else if (dec_en) begin
			bal_reg <= data_sync_reg[1] ? bal_reg + 8'sh01
				: bal_reg - 8'sh01;
		end
	end

	// slice source select
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			slice_out <= SLICE_MID;
		end else begin
			case (slice_src_in)
			SLICE_TRIM: slice_out <= slice_trim_in;
			SLICE_USER: slice_out <= slice_user_in;
			SLICE_AUTO: slice_out <= auto_slice_reg;
			default:    slice_out <= slice_trim_in;
			endcase
		end
	end

	// adaptation only when locked in the top octave above 5.5G
	assign eq_allowed = eq_adapt_en_in && (acq_reg == ACQ_LOCKED)
		&& (div_reg == '0) && (base_reg >= EQ_MIN_OSC);
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			eq_boost_out <= 4'h0;
		end else if (!eq_allowed) begin
			eq_boost_out <= eq_boost_in;
		end else if (tick) begin
			if (eq_more_boost_in && eq_boost_out != 4'hf) begin
				eq_boost_out <= eq_boost_out + 4'h1;
			end else if (!eq_more_boost_in && eq_boost_out != 4'h0) begin
				eq_boost_out <= eq_boost_out - 4'h1;
			end
		end
	end

	// packer: a wrap back drops the bit, a wrap forward repeats it
	assign shift_ok  = !(wr_valid_reg && !wr_ready);
	assign shift_val = (dec_en && !wrap_dn) || (dup_reg && !dec_en);
	assign shift_bit = dec_en ? data_sync_reg[1] : d_prev_reg;
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pack_reg     <= '0;
			pack_cnt_reg <= 2'h0;
			dup_reg      <= 1'b0;
			wr_valid_reg <= 1'b0;
			overflow_out <= 1'b0;
		end else begin
			if (wr_valid_reg && wr_ready) begin
				wr_valid_reg <= 1'b0;
			end
			if (wrap_up) begin
				dup_reg <= 1'b1;
			end else if (dup_reg && !dec_en && shift_ok) begin
				dup_reg <= 1'b0;
			end
			if (shift_val && !shift_ok) begin
				overflow_out <= 1'b1; // stalled reader lost a bit
			end else if (shift_val) begin
				pack_reg     <= {pack_reg[PACK_W-2:0], shift_bit};
				pack_cnt_reg <= pack_cnt_reg + 2'h1;
				if (pack_cnt_reg == 2'h3) begin
					wr_valid_reg <= 1'b1;
				end
			end
		end
	end

	// eight words of four bits give 32 UI of slack
	retime_fifo #(
		.WIDTH (PACK_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clock_in      (clock_in),
		.arst_n_in     (arst_n_in),
		.in_valid_in   (wr_valid_reg),
		.in_ready_out  (wr_ready),
		.in_data_in    (pack_reg),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_take),
		.out_data_out  (fifo_data)
	);

	// registered output stage so the ports come from flops
	assign fifo_take = fifo_valid && (!rd_valid_out || rd_ready_in);
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out  <= '0;
		end else if (fifo_take) begin
			rd_valid_out <= 1'b1;
			rd_data_out  <= fifo_data;
		end else if (rd_ready_in) begin
			rd_valid_out <= 1'b0;
		end
	end
endmodule

// *** hdl/cdr_pkg.sv ***
// shared constants and types for the cdr loop control block
package cdr_pkg;
	// front-end path choice, as programmed
	localparam logic [1:0] SEL_LIMAMP = 2'h0;
	localparam logic [1:0] SEL_EQ     = 2'h1;
	localparam logic [1:0] SEL_UNITY  = 2'h2;
	// one-hot path enables, all zero for no path
	localparam logic [2:0] PATH_LIMAMP = 3'h1;
	localparam logic [2:0] PATH_EQ     = 3'h2;
	localparam logic [2:0] PATH_UNITY  = 3'h4;
	localparam logic [2:0] PATH_NONE   = 3'h0;
	// slice threshold sources
	localparam logic [1:0] SLICE_TRIM = 2'h0;
	localparam logic [1:0] SLICE_USER = 2'h1;
	localparam logic [1:0] SLICE_AUTO = 2'h2;
	localparam logic [6:0] SLICE_MID  = 7'h40;
	localparam logic [6:0] SLICE_MAX  = 7'h7f;
	localparam logic [6:0] SLICE_MIN  = 7'h01;
	// loss-of-signal thresholds in mV peak-to-peak
	localparam logic [7:0] LOS_MAX_MV  = 8'h80;
	localparam logic [7:0] LOS_DEF_MV  = 8'h0a;
	localparam logic [7:0] LOS_HYST_MV = 8'h04;
	// widths of the loop words
	localparam int DIV_W = 4;
	localparam int OSC_W = 12;
	localparam int INT_W = 16;
	localparam int PH_W  = 5;
	localparam int PPM_W = 12;
	localparam int PACK_W = 4;
	localparam int FIFO_D = 8;
	localparam logic [DIV_W-1:0] DIV_MAX  = 4'hb;
	localparam logic [OSC_W-1:0] OSC_MIN  = 12'h000;
	localparam logic [OSC_W-1:0] OSC_MAX  = 12'hfff;
	localparam logic [OSC_W-1:0] STEP_INIT = 12'h100;
	localparam logic [OSC_W-1:0] STEP_MIN = 12'h001;
	// oscillator code above which the rate exceeds 5.5 Gbps at N = 1
	localparam logic [OSC_W-1:0] EQ_MIN_OSC = 12'h900;
	localparam int INT_SHIFT = 4;
	localparam logic [PH_W-1:0] PH_CENTER = 5'h10;
	localparam logic [PH_W-1:0] PH_TOP    = 5'h1f;
	// frequency windows in ppm
	localparam logic [PPM_W-1:0] LOCK_PPM = 12'h0fa;
	localparam logic [PPM_W-1:0] LOSS_PPM = 12'h3e8;
	// slow housekeeping tick for centring and adaptation
	localparam logic [7:0] TICK_TOP = 8'h3f;
	localparam logic signed [7:0] BAL_LIM = 8'sh20;
	// result of one frequency comparison
	typedef struct packed {
		logic             valid;
		logic             samp_fast;
		logic [PPM_W-1:0] diff_ppm;
	} freq_cmp_t;
	typedef enum logic [1:0] {
		ACQ_RESET   = 2'b00,
		ACQ_MEASURE = 2'b01,
		ACQ_LOCKED  = 2'b10
	} acq_state_t;
endpackage

// *** testbench/cdr_loop_control_sva.sv ***
// port assertions for the cdr loop control block
`timescale 1ns/1ns
module cdr_loop_control_sva
	import cdr_pkg::*;
(
	// clock and reset
	input wire logic        clock_in,
	input wire logic        arst_n_in,
	// controls
	input wire logic [1:0]  input_sel_in,
	input wire logic [7:0]  los_thresh_in,
	input wire logic [7:0]  signal_level_in,
	input wire logic [1:0]  slice_src_in,
	input wire logic [6:0]  slice_user_in,
	input wire logic [6:0]  slice_trim_in,
	input wire logic        eq_adapt_en_in,
	input wire logic [3:0]  eq_boost_in,
	input wire logic        ref_mode_in,
	input wire logic        rd_ready_in,
	// observed outputs
	input wire logic        rd_valid_out,
	input wire logic [3:0]  rd_data_out,
	input wire logic [2:0]  path_sel_out,
	input wire logic        signal_loss_detect_out,
	input wire logic [6:0]  slice_out,
	input wire logic [3:0]  eq_boost_out,
	input wire logic [3:0]  div_exp_out,
	input wire logic [11:0] digital_osc_out,
	input wire logic [4:0]  phase_shifter_out,
	input wire logic        osc_sat_out,
	input wire logic        lock_loss_flag_out,
	input wire logic        pll_en_out,
	input wire logic        overflow_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);

	// config outputs follow one cycle late; $past(reset) skips release
	path_onehot_a: assert property ($past(arst_n_in) |->
		path_sel_out == ($past(input_sel_in) == 2'h3 ? PATH_NONE :
		3'h1 << $past(input_sel_in))) else $error("path select wrong");
	loss_limamp_only_a: assert property ($past(arst_n_in) &&
		$past(input_sel_in) != SEL_LIMAMP |-> !signal_loss_detect_out)
		else $error("loss alarm off limiting path");
	loss_cap_a: assert property ($past(arst_n_in) &&
		$past(input_sel_in) == SEL_LIMAMP && $past(los_thresh_in) == 8'hff
		&& $past(signal_level_in) == 8'h7f |-> signal_loss_detect_out)
		else $error("loss threshold not capped");
	slice_src_a: assert property ($past(arst_n_in) &&
		$past(slice_src_in) != SLICE_AUTO |-> slice_out ==
		($past(slice_src_in) == SLICE_USER ? $past(slice_user_in) :
		$past(slice_trim_in))) else $error("slice source wrong");
	boost_manual_a: assert property ($past(arst_n_in) &&
		!$past(eq_adapt_en_in) |-> eq_boost_out == $past(eq_boost_in))
		else $error("manual boost not applied");
	sat_extreme_a: assert property (osc_sat_out |->
		digital_osc_out == OSC_MIN || digital_osc_out == OSC_MAX)
		else $error("saturation off the extremes");
	lock_pll_a: assert property (pll_en_out |-> !lock_loss_flag_out)
		else $error("phase loop on while unlocked");
	// the ratio output trails the flag by one cycle on a restart
	restart_low_a: assert property ($rose(lock_loss_flag_out) &&
		!ref_mode_in |=> div_exp_out == 4'h0)
		else $error("restart kept decimation");
	div_double_a: assert property (!ref_mode_in && !$past(ref_mode_in) &&
		$changed(div_exp_out) && $past(lock_loss_flag_out, 2) |->
		div_exp_out == $past(div_exp_out) + 4'h1)
		else $error("decimation not doubled");
	fifo_hold_a: assert property (rd_valid_out && !rd_ready_in |=>
		rd_valid_out && $stable(rd_data_out)) else $error("word not held");
	ovf_sticky_a: assert property (overflow_out |=> overflow_out)
		else $error("overflow cleared");
	// centring and decisions never move the shifter by more than one step
	shift_step_a: assert property ($past(arst_n_in) |->
		5'(phase_shifter_out - $past(phase_shifter_out)) inside
		{5'h0, 5'h1, 5'h1f}) else $error("shifter jumped");

	// main scenarios reached
	lock_c: cover property ($fell(lock_loss_flag_out));
	ovf_c: cover property ($rose(overflow_out));
	stall_c: cover property (rd_valid_out && !rd_ready_in);
endmodule

bind cdr_loop_control cdr_loop_control_sva chk (
	.clock_in, .arst_n_in, .input_sel_in, .los_thresh_in,
	.signal_level_in, .slice_src_in, .slice_user_in, .slice_trim_in,
	.eq_adapt_en_in, .eq_boost_in, .ref_mode_in, .rd_ready_in,
	.rd_valid_out, .rd_data_out, .path_sel_out, .signal_loss_detect_out,
	.slice_out, .eq_boost_out, .div_exp_out, .digital_osc_out,
	.phase_shifter_out, .osc_sat_out, .lock_loss_flag_out, .pll_en_out,
	.overflow_out
);

// *** testbench/cdr_loop_control_tb.sv ***
// self-checking bench for the cdr loop control block
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module cdr_loop_control_tb;
	import cdr_pkg::*;
	logic        clock_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [1:0]  input_sel_in = 2'h0;
	logic [7:0]  los_thresh_in = 8'h0;
	logic [7:0]  signal_level_in = 8'hff;
	logic [1:0]  slice_src_in = 2'h0;
	logic [6:0]  slice_user_in = 7'h2a;
	logic [6:0]  slice_trim_in = 7'h35;
	logic        eq_adapt_en_in = 1'b0;
	logic [3:0]  eq_boost_in = 4'h5;
	logic        eq_more_boost_in = 1'b1;
	freq_cmp_t   freq_cmp_in = '0;
	logic        ref_mode_in = 1'b0;
	logic [3:0]  ref_div_in = 4'h3;
	logic        rd_ready_in = 1'b1;
	logic [1:0]  mode = 2'h0;
	logic        data_samp;
	logic        edge_samp;
	logic        rd_valid_out;
	logic [3:0]  rd_data_out;
	logic [2:0]  path_sel_out;
	logic        loss;
	logic [6:0]  slice_out;
	logic [3:0]  eq_boost_out;
	logic [3:0]  div_exp_out;
	logic [11:0] digital_osc_out;
	logic [4:0]  phase_shifter_out;
	logic        osc_sat_out;
	logic        lock_loss_flag_out;
	logic        pll_en_out;
	logic        overflow_out;
	int          fails = 0;
	int          tests_run = 0;
	int          n;

	// 250 MHz clock
	always #2 clock_in = ~clock_in;

	cdr_loop_control dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.input_sel_in(input_sel_in), .los_thresh_in(los_thresh_in),
		.signal_level_in(signal_level_in), .slice_src_in(slice_src_in),
		.slice_user_in(slice_user_in), .slice_trim_in(slice_trim_in),
		.eq_adapt_en_in(eq_adapt_en_in), .eq_boost_in(eq_boost_in),
		.eq_more_boost_in(eq_more_boost_in), .data_samp_in(data_samp),
		.edge_samp_in(edge_samp), .freq_cmp_in(freq_cmp_in),
		.ref_mode_in(ref_mode_in), .ref_div_in(ref_div_in),
		.rd_ready_in(rd_ready_in), .rd_valid_out(rd_valid_out),
		.rd_data_out(rd_data_out), .path_sel_out(path_sel_out),
		.signal_loss_detect_out(loss), .slice_out(slice_out),
		.eq_boost_out(eq_boost_out), .div_exp_out(div_exp_out),
		.digital_osc_out(digital_osc_out),
		.phase_shifter_out(phase_shifter_out), .osc_sat_out(osc_sat_out),
		.lock_loss_flag_out(lock_loss_flag_out), .pll_en_out(pll_en_out),
		.overflow_out(overflow_out));

	nrz_source src (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.mode_in(mode), .div_exp_in(div_exp_out),
		.data_samp_out(data_samp), .edge_samp_out(edge_samp));

	task automatic cyc(input int k);
		repeat (k) @(negedge clock_in);
	endtask

	// one comparator result as a single-cycle pulse, then flags settle
	task automatic freq(input logic fast, input logic [11:0] ppm);
		freq_cmp_in = '{1'b1, fast, ppm};
		cyc(1);
		freq_cmp_in.valid = 1'b0;
		cyc(3);
	endtask

	task automatic tally_and_finish();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// hang guard well above the run length of the sequence
	initial begin
		#100000;
		fails++;
		tally_and_finish();
	end

	// main sequence, inputs change on the falling edge
	initial begin
		cyc(2);
		`CHK({path_sel_out, slice_out}, {PATH_LIMAMP, SLICE_MID})
		`CHK(phase_shifter_out, PH_CENTER)
		`CHK({lock_loss_flag_out, pll_en_out, overflow_out}, 3'h4)
		`CHK({div_exp_out, digital_osc_out}, 16'h0)
		arst_n_in = 1'b1;
		los_thresh_in = 8'hff;
		signal_level_in = 8'h7f;
		cyc(2);
		`CHK(loss, 1'b1)
		signal_level_in = 8'h83;
		cyc(1);
		`CHK(loss, 1'b1)
		signal_level_in = 8'h84;
		cyc(1);
		`CHK(loss, 1'b0)
		los_thresh_in = 8'h00;
		signal_level_in = 8'h09;
		cyc(1);
		`CHK(loss, 1'b1)
		for (int s = 0; s < 4; s++) begin
			input_sel_in = 2'(s);
			cyc(1);
			`CHK(path_sel_out, (s == 3) ? PATH_NONE : 3'(1 << s))
			`CHK(loss, (s == 0))
		end
		input_sel_in = SEL_LIMAMP;
		for (int s = 0; s < 4; s++) begin
			slice_src_in = 2'(s);
			cyc(1);
			if (s != 2) `CHK(slice_out, (s == 1) ? slice_user_in : slice_trim_in)
		end
		eq_boost_in = 4'hb;
		cyc(1);
		`CHK(eq_boost_out, 4'hb)
		// acquisition: double N once, two coarse steps, one halved step back
		freq(1'b1, 12'h7d0);
		`CHK(div_exp_out, 4'h1)
		freq(1'b0, 12'h7d0);
		`CHK(digital_osc_out, 12'h100)
		freq(1'b0, 12'h5dc);
		`CHK(digital_osc_out, 12'h200)
		freq(1'b1, 12'h3e8);
		`CHK(digital_osc_out, 12'h180)
		freq(1'b0, LOCK_PPM);
		`CHK({lock_loss_flag_out, pll_en_out}, 2'b01)
		mode = 2'h1;
		cyc(80);
		`CHK((digital_osc_out > 12'h180), 1'b1)
		`CHK((phase_shifter_out != PH_CENTER), 1'b1)
		mode = 2'h2;
		slice_src_in = SLICE_AUTO;
		cyc(200);
		`CHK((digital_osc_out < 12'h180), 1'b1)
		slice_src_in = SLICE_TRIM;
		freq(1'b0, LOSS_PPM);
		`CHK(lock_loss_flag_out, 1'b0)
		// steady ones; stall the reader until the fifo refuses
		mode = 2'h0;
		cyc(40);
		rd_ready_in = 1'b0;
		cyc(120);
		`CHK({overflow_out, rd_valid_out}, 2'b11)
		rd_ready_in = 1'b1;
		n = 0;
		repeat (24) begin
			if (rd_valid_out === 1'b1) begin
				n++;
				`CHK(rd_data_out, 4'hf)
			end
			cyc(1);
		end
		`CHK((n >= FIFO_D), 1'b1)
		ref_mode_in = 1'b1;
		freq(1'b0, 12'h3e9);
		`CHK({lock_loss_flag_out, div_exp_out}, {1'b1, ref_div_in})
		freq(1'b1, 12'h7d0);
		`CHK(div_exp_out, ref_div_in)
		ref_mode_in = 1'b0;
		freq(1'b0, 12'h064);
		`CHK(lock_loss_flag_out, 1'b0)
		// locked at the bottom of the range: an early clock drives it below
		mode = 2'h2;
		cyc(40);
		`CHK({osc_sat_out, digital_osc_out}, {1'b1, OSC_MIN})
		mode = 2'h0;
		freq(1'b0, 12'h3e9);
		`CHK({lock_loss_flag_out, div_exp_out}, 5'h10)
		// nine coarse steps up reach the top octave, then adapt the boost
		repeat (9) freq(1'b0, 12'h7d0);
		freq(1'b0, LOCK_PPM);
		`CHK({lock_loss_flag_out, digital_osc_out}, 13'h0900)
		eq_adapt_en_in = 1'b1;
		cyc(70);
		`CHK((eq_boost_out > 4'hb), 1'b1)
		eq_adapt_en_in = 1'b0;
		arst_n_in = 1'b0;
		cyc(2);
		`CHK(overflow_out, 1'b0)
		arst_n_in = 1'b1;
		cyc(4);
		tally_and_finish();
	end
endmodule

// *** testbench/nrz_source.sv ***
// serial nrz data source driving the sampler pins
`timescale 1ns/1ns
module nrz_source (
	// clock and reset
	input  wire logic       clock_in,
	input  wire logic       arst_n_in,
	// commanded behaviour: 0 steady ones, 1 clock late, 2 clock early
	input  wire logic [1:0] mode_in,
	input  wire logic [3:0] div_exp_in,
	// sampler pins
	output logic            data_samp_out,
	output logic            edge_samp_out
);
	logic [15:0] ui_cnt_reg;
	logic        bit_reg;

	// one bit per decision period, so every decision sees a transition
	always_ff @(negedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ui_cnt_reg <= 16'h0;
			bit_reg    <= 1'b0;
		end else if (ui_cnt_reg >= (16'h1 << div_exp_in) - 16'h1) begin
			ui_cnt_reg <= 16'h0;
			bit_reg    <= ~bit_reg;
		end else begin
			ui_cnt_reg <= ui_cnt_reg + 16'h1;
		end
	end

	// late: edge sample already shows the new bit; early: still the old one
	always_comb begin
		data_samp_out = (mode_in == 2'h0) ? 1'b1 : bit_reg;
		edge_samp_out = (mode_in == 2'h2) ? ~bit_reg : data_samp_out;
	end
endmodule
